// >>> rtl/hgac_regs.vh
`ifndef HGAC_REGS_VH
`define HGAC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define HGAC_OFF_CTRL    8'h00
`define HGAC_OFF_SCAUSE  8'h04
`define HGAC_OFF_STVAL   8'h08
`define HGAC_OFF_SATP    8'h0C
`define HGAC_OFF_VSCAUSE 8'h10
`define HGAC_OFF_VSTVAL  8'h14
`define HGAC_OFF_VSATP   8'h18
`define HGAC_OFF_INSTR   8'h1C
`define HGAC_OFF_RS1     8'h20
`define HGAC_OFF_RS2     8'h24
`define HGAC_OFF_RESULT  8'h28
`define HGAC_OFF_FADDR   8'h2C
`define HGAC_OFF_FID     8'h30

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define HGAC_CTL_PRIV_LO 0
`define HGAC_CTL_PRIV_HI 1
`define HGAC_CTL_VIRT    2
`define HGAC_CTL_UHA     3
`define HGAC_CTL_GPRIV   4
`define HGAC_CTL_MTRAP   5
`define HGAC_CTL_HVTRAP  6
`define HGAC_CTL_XRD     7
`define HGAC_CTL_GXRD    8
`define HGAC_CTL_SUM     9
`define HGAC_CTL_X64     10
`define HGAC_CTL_SPEC    11
`define HGAC_CTL_W       12
`define HGAC_CTL_RESET   12'h003

// ----------------------------------------------------------------
// privilege levels and exception codes
// ----------------------------------------------------------------
`define HGAC_PRIV_U 2'h0
`define HGAC_PRIV_S 2'h1
`define HGAC_PRIV_M 2'h3
`define HGAC_EXC_NONE 2'h0
`define HGAC_EXC_ILL  2'h1
`define HGAC_EXC_VIRT 2'h2

// ----------------------------------------------------------------
// instruction encodings
// ----------------------------------------------------------------
`define HGAC_OPC_SYSTEM 7'h73
`define HGAC_F3_PRIV    3'h0
`define HGAC_F3_PRIVM   3'h4
`define HGAC_F7_VFENCE  7'h11
`define HGAC_F7_GFENCE  7'h31
`define HGAC_F7_LD_B    7'h30
`define HGAC_F7_LD_H    7'h32
`define HGAC_F7_LD_W    7'h34
`define HGAC_F7_LD_D    7'h36
`define HGAC_F7_ST_B    7'h31
`define HGAC_F7_ST_H    7'h33
`define HGAC_F7_ST_W    7'h35
`define HGAC_F7_ST_D    7'h37
`define HGAC_LDSEL_SGN  5'h00
`define HGAC_LDSEL_UNS  5'h01
`define HGAC_LDSEL_EXE  5'h03

// ----------------------------------------------------------------
// cause / translation layout, identifier widths
// ----------------------------------------------------------------
`define HGAC_CAUSE_MASK  32'h8000001F
`define HGAC_SATP_MODE   31
`define HGAC_PAGED_OK    1'b1
`define HGAC_ASIDLEN     6
`define HGAC_VMIDLEN     5
`define HGAC_GPA_SHIFT   2

`endif

// >>> rtl/hgac_top.v
// Operation
// - virtualization on: cause and trap-value accesses use guest copies
// - guest cause holds exactly the legal values of the supervisor cause
// - guest trap value is write-any-read-legal like the supervisor one
// - virtualization on: translation-control accesses use the guest copy
// - guest translation active except effective user with access bit clear
// - speculation sets no first-stage accessed bits outside guest modes
// - unsupported translation scheme writes are ignored in both modes
// - guest load/store only in machine, hypervisor or user with access bit
// - access privilege bit picks guest user or guest supervisor level
// - two-stage guest access; host user bit ignored; exec-readable split
// - all load/store widths; unsigned word and doubleword not on 32-bit
// - exec loads check execute in both stages; attributes need both
// - execute-permission load faults report as load faults
// - execute-permission unsigned word load is valid on 32-bit base
// - guest load/store: virtual fault if virtualized, illegal in user without access bit
// - virtual fence orders stores, nonzero operands pick address and id
// - virtual fence ignores space id bits above the implemented width
// - virtual fence only in machine or hypervisor; trap-vm bits ignored
// - physical fence: machine always, hypervisor if trap-vm bit clear
// - physical fence: address operand shifted right two; second picks id
// - physical fence ignores machine id bits above the implemented width
// - either fence: virtual fault if virtualized, illegal in user mode
`timescale 1ns/1ps
`include "hgac_regs.vh"
`default_nettype none

module hgac_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg illegal_pulse,
    output reg virtual_pulse,
    output reg guest_access_pulse,
    output reg vfence_pulse,
    output reg gfence_pulse
);

    // ------------------------------------------------------------
    // state machine of the instruction checker
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b01;
    localparam ST_EVAL = 2'b10;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // reserved and unimplemented identifier bits read as ignored
    function [31:0] id_mask;
        input [31:0] val;
        input integer len;
        integer i;
        begin
            for (i = 0; i < 32; i = i + 1) begin
                id_mask[i] = (i < len) ? val[i] : 1'b0;
            end
        end
    endfunction

    function mode_ok;
        input [31:0] val;
        begin
            mode_ok = ~val[`HGAC_SATP_MODE] | `HGAC_PAGED_OK;
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [`HGAC_CTL_W-1:0] ctrl_q;
    reg [31:0] scause_q, stval_q, satp_q;
    reg [31:0] vscause_q, vstval_q, vsatp_q;
    reg [31:0] instr_q, rs1_q, rs2_q;
    reg [31:0] result_q, faddr_q, fid_q;
    reg [1:0] state_q;
    reg [31:0] result_d, faddr_d, fid_d;

    wire [1:0] priv = ctrl_q[`HGAC_CTL_PRIV_HI:`HGAC_CTL_PRIV_LO];
    wire virt = ctrl_q[`HGAC_CTL_VIRT] & (priv != `HGAC_PRIV_M);
    wire uha = ctrl_q[`HGAC_CTL_UHA];
    wire gpriv = ctrl_q[`HGAC_CTL_GPRIV];
    wire mtrap = ctrl_q[`HGAC_CTL_MTRAP];
    wire x64 = ctrl_q[`HGAC_CTL_X64];
    wire spec = ctrl_q[`HGAC_CTL_SPEC];

    wire setup = psel & ~penable;
    wire acc = psel & penable & pready;
    wire wr = acc & pwrite;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    reg hit;
    reg [31:0] rd_d;
    always @* begin
        hit = 1'b1;
        rd_d = 32'h00000000;
        case (paddr)
            `HGAC_OFF_CTRL: rd_d = {20'h00000, ctrl_q};
            // supervisor views follow the virtualization mode
            `HGAC_OFF_SCAUSE: rd_d = virt ? vscause_q : scause_q;
            `HGAC_OFF_STVAL: rd_d = virt ? vstval_q : stval_q;
            `HGAC_OFF_SATP: rd_d = virt ? vsatp_q : satp_q;
            `HGAC_OFF_VSCAUSE: rd_d = vscause_q;
            `HGAC_OFF_VSTVAL: rd_d = vstval_q;
            `HGAC_OFF_VSATP: rd_d = vsatp_q;
            `HGAC_OFF_INSTR: rd_d = instr_q;
            `HGAC_OFF_RS1: rd_d = rs1_q;
            `HGAC_OFF_RS2: rd_d = rs2_q;
            `HGAC_OFF_RESULT: rd_d = result_q;
            `HGAC_OFF_FADDR: rd_d = faddr_q;
            `HGAC_OFF_FID: rd_d = fid_q;
            default: hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // apb slave: one access cycle, no wait states
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h00000000 : rd_d;
                pslverr <= ~hit;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // csr storage
    // ------------------------------------------------------------
    wire w_scause = wr & (paddr == `HGAC_OFF_SCAUSE);
    wire w_stval = wr & (paddr == `HGAC_OFF_STVAL);
    wire w_satp = wr & (paddr == `HGAC_OFF_SATP);
    wire w_vscause = wr & (paddr == `HGAC_OFF_VSCAUSE);
    wire w_vstval = wr & (paddr == `HGAC_OFF_VSTVAL);
    wire w_vsatp = wr & (paddr == `HGAC_OFF_VSATP);
    wire w_instr = wr & (paddr == `HGAC_OFF_INSTR);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= `HGAC_CTL_RESET;
            scause_q <= 32'h00000000;
            stval_q <= 32'h00000000;
            satp_q <= 32'h00000000;
            vscause_q <= 32'h00000000;
            vstval_q <= 32'h00000000;
            vsatp_q <= 32'h00000000;
            rs1_q <= 32'h00000000;
            rs2_q <= 32'h00000000;
        end else begin
            if (wr & (paddr == `HGAC_OFF_CTRL)) begin
                ctrl_q <= pwdata[`HGAC_CTL_W-1:0];
            end
            if (wr & (paddr == `HGAC_OFF_RS1)) begin
                rs1_q <= pwdata;
            end
            if (wr & (paddr == `HGAC_OFF_RS2)) begin
                rs2_q <= pwdata;
            end
            // guest copy takes the same legal cause values
            if ((w_scause & virt) | w_vscause) begin
                vscause_q <= pwdata & `HGAC_CAUSE_MASK;
            end
            if (w_scause & ~virt) begin
                scause_q <= pwdata & `HGAC_CAUSE_MASK;
            end
            if ((w_stval & virt) | w_vstval) begin
                vstval_q <= pwdata;
            end
            if (w_stval & ~virt) begin
                stval_q <= pwdata;
            end
            // unsupported scheme leaves either copy untouched
            if (((w_satp & virt) | w_vsatp) & mode_ok(pwdata)) begin
                vsatp_q <= pwdata;
            end
            if (w_satp & ~virt & mode_ok(pwdata)) begin
                satp_q <= pwdata;
            end
        end
    end

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    wire [6:0] f7 = instr_q[31:25];
    wire [4:0] rs2f = instr_q[24:20];
    wire [4:0] rs1f = instr_q[19:15];
    wire [2:0] f3 = instr_q[14:12];
    wire [4:0] rdf = instr_q[11:7];
    wire sys = instr_q[6:0] == `HGAC_OPC_SYSTEM;
    wire privm = sys & (f3 == `HGAC_F3_PRIVM);
    wire is_vf = sys & (f3 == `HGAC_F3_PRIV) & (f7 == `HGAC_F7_VFENCE) &
        (rdf == 5'h00);
    wire is_gf = sys & (f3 == `HGAC_F3_PRIV) & (f7 == `HGAC_F7_GFENCE) &
        (rdf == 5'h00);

    reg ld, st, xp, sgn, bad;
    reg [1:0] sz;
    always @* begin
        ld = 1'b0;
        st = 1'b0;
        xp = 1'b0;
        sgn = 1'b0;
        bad = 1'b0;
        sz = 2'h0;
        if (privm) begin
            case (f7)
                `HGAC_F7_LD_B, `HGAC_F7_LD_H, `HGAC_F7_LD_W,
                `HGAC_F7_LD_D: begin
                    ld = 1'b1;
                    sz = f7[2:1];
                    sgn = rs2f == `HGAC_LDSEL_SGN;
                    xp = rs2f == `HGAC_LDSEL_EXE;
                    bad = ~(sgn | xp | (rs2f == `HGAC_LDSEL_UNS));
                    if ((f7 == `HGAC_F7_LD_B) & xp) begin
                        bad = 1'b1;
                    end
                    if ((f7 == `HGAC_F7_LD_D) & ~sgn) begin
                        bad = 1'b1;
                    end
                    // unsigned word only on 64-bit, exec variant always
                    if (~x64 & (f7 == `HGAC_F7_LD_W) & ~sgn & ~xp) begin
                        bad = 1'b1;
                    end
                    if (~x64 & (f7 == `HGAC_F7_LD_D)) begin
                        bad = 1'b1;
                    end
                end
                `HGAC_F7_ST_B, `HGAC_F7_ST_H, `HGAC_F7_ST_W,
                `HGAC_F7_ST_D: begin
                    st = 1'b1;
                    sz = f7[2:1];
                    bad = (rdf != 5'h00) | (~x64 & (f7 == `HGAC_F7_ST_D));
                end
                default: bad = 1'b1;
            endcase
        end else if (~is_vf & ~is_gf) begin
            bad = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // legality and access attributes
    // ------------------------------------------------------------
    wire gmem = ld | st;
    reg [1:0] exc;
    always @* begin
        exc = `HGAC_EXC_NONE;
        if (bad) begin
            exc = `HGAC_EXC_ILL;
        end else if (gmem) begin
            if (virt) begin
                exc = `HGAC_EXC_VIRT;
            end else if ((priv == `HGAC_PRIV_U) & ~uha) begin
                exc = `HGAC_EXC_ILL;
            end
        end else begin
            // trap-vm bits never stop the virtual fence
            if (virt) begin
                exc = `HGAC_EXC_VIRT;
            end else if (priv == `HGAC_PRIV_U) begin
                exc = `HGAC_EXC_ILL;
            end else if (is_gf & (priv == `HGAC_PRIV_S) & mtrap) begin
                exc = `HGAC_EXC_ILL;
            end
        end
    end

    // guest load/store runs at the level the privilege bit picks
    wire acc_vs = gmem ? gpriv : (priv != `HGAC_PRIV_U);
    wire eff_u = ~acc_vs;
    wire guest_eff = gmem | virt;
    wire vs_active = guest_eff & ~(eff_u & ~uha);
    wire abit_ok = guest_eff & ~(spec & ~virt);

    always @* begin
        result_d = 32'h00000000;
        faddr_d = 32'h00000000;
        fid_d = 32'h00000000;
        result_d[1:0] = exc;
        result_d[2] = 1'b1;
        result_d[3] = ld;
        result_d[4] = st;
        result_d[5] = xp;
        result_d[6] = sgn;
        result_d[8:7] = sz;
        result_d[9] = acc_vs;
        result_d[10] = gmem;
        // host user-access bit never applies to guest accesses
        result_d[11] = ~gmem & ctrl_q[`HGAC_CTL_SUM];
        result_d[12] = ctrl_q[`HGAC_CTL_XRD];
        result_d[13] = ctrl_q[`HGAC_CTL_XRD] | ctrl_q[`HGAC_CTL_GXRD];
        result_d[14] = vs_active;
        result_d[15] = abit_ok;
        result_d[16] = is_vf;
        result_d[17] = is_gf;
        result_d[18] = (is_vf | is_gf) & (rs1f != 5'h00);
        result_d[19] = (is_vf | is_gf) & (rs2f != 5'h00);
        // exec loads still fault with load causes
        result_d[20] = ld;
        result_d[21] = xp;
        if (is_vf) begin
            faddr_d = rs1f != 5'h00 ? rs1_q : 32'h00000000;
            fid_d = rs2f != 5'h00 ?
                id_mask(rs2_q, `HGAC_ASIDLEN) : 32'h00000000;
        end else if (is_gf) begin
            // operand already holds the address shifted by two
            faddr_d = rs1f != 5'h00 ? rs1_q : 32'h00000000;
            fid_d = rs2f != 5'h00 ?
                id_mask(rs2_q, `HGAC_VMIDLEN) : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // checker sequencing and event pulses
    // ------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            instr_q <= 32'h00000000;
            result_q <= 32'h00000000;
            faddr_q <= 32'h00000000;
            fid_q <= 32'h00000000;
            illegal_pulse <= 1'b0;
            virtual_pulse <= 1'b0;
            guest_access_pulse <= 1'b0;
            vfence_pulse <= 1'b0;
            gfence_pulse <= 1'b0;
        end else begin
            illegal_pulse <= 1'b0;
            virtual_pulse <= 1'b0;
            guest_access_pulse <= 1'b0;
            vfence_pulse <= 1'b0;
            gfence_pulse <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (w_instr) begin
                        instr_q <= pwdata;
                        result_q <= 32'h00000000;
                        state_q <= ST_EVAL;
                    end
                end
                ST_EVAL: begin
                    result_q <= result_d;
                    faddr_q <= faddr_d;
                    fid_q <= fid_d;
                    illegal_pulse <= exc == `HGAC_EXC_ILL;
                    virtual_pulse <= exc == `HGAC_EXC_VIRT;
                    if (exc == `HGAC_EXC_NONE) begin
                        guest_access_pulse <= gmem;
                        vfence_pulse <= is_vf;
                        gfence_pulse <= is_gf;
                    end
                    state_q <= ST_IDLE;
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> bench/hgac_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "hgac_regs.vh"
module hgac_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic illegal_pulse,
    input wire logic virtual_pulse,
    input wire logic guest_access_pulse,
    input wire logic vfence_pulse,
    input wire logic gfence_pulse
);
    // ----------------------------------------------------------------
    // mode mirror and decode of the written instruction
    // ----------------------------------------------------------------
    logic [11:0] ctl_q;
    logic [4:0] pul;
    logic wr, ins, ld, vf, gf, m, s, u, vt, uha;
    assign pul = {illegal_pulse, virtual_pulse, guest_access_pulse,
        vfence_pulse, gfence_pulse};
    assign wr = psel && penable && pready && pwrite;
    assign ins = wr && paddr == `HGAC_OFF_INSTR;
    assign m = ctl_q[1:0] == `HGAC_PRIV_M;
    assign s = ctl_q[1:0] == `HGAC_PRIV_S;
    assign u = ctl_q[1:0] == `HGAC_PRIV_U;
    // virtualization bit means nothing in machine mode
    assign vt = ctl_q[`HGAC_CTL_VIRT] && !m;
    assign uha = ctl_q[`HGAC_CTL_UHA];
    assign ld = ins && pwdata[31:20] == {`HGAC_F7_LD_B, `HGAC_LDSEL_SGN}
        && pwdata[14:12] == `HGAC_F3_PRIVM
        && pwdata[6:0] == `HGAC_OPC_SYSTEM;
    assign vf = ins && pwdata[31:25] == `HGAC_F7_VFENCE
        && pwdata[14:0] == {`HGAC_F3_PRIV, 5'h00, `HGAC_OPC_SYSTEM};
    assign gf = ins && pwdata[31:25] == `HGAC_F7_GFENCE
        && pwdata[14:0] == {`HGAC_F3_PRIV, 5'h00, `HGAC_OPC_SYSTEM};
    // mode word only changes through a completed write, same as inside
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= `HGAC_CTL_RESET;
        end else if (wr && paddr == `HGAC_OFF_CTRL) begin
            ctl_q <= pwdata[11:0];
        end
    end
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_ONE_OUTCOME: assert property (ins |-> ##2 $onehot(pul))
        else $error("instruction check gave not exactly one outcome");
    AST_NO_STRAY: assert property (|pul |-> $past(ins, 2))
        else $error("outcome pulse without instruction write");
    AST_LD_VIRT: assert property (ld && vt |-> ##2 virtual_pulse)
        else $error("guest load while virtualized not virtual fault");
    AST_LD_USER: assert property (ld && u && !vt && !uha
        |-> ##1 pul == 5'h00 ##1 illegal_pulse)
        else $error("guest load from user without access bit not illegal");
    AST_LD_OK: assert property (ld && !vt && (m || s || (u && uha))
        |-> ##2 guest_access_pulse)
        else $error("permitted guest load not accepted");
    AST_VF_OK: assert property (vf && !vt && (m || s)
        |-> ##2 vfence_pulse)
        else $error("virtual fence refused in host mode");
    AST_GF_HOST: assert property (gf && !vt && s
        |-> ##2 (ctl_q[`HGAC_CTL_MTRAP] ? illegal_pulse : gfence_pulse))
        else $error("physical fence in host supervisor mishandled");
    AST_GF_MACH: assert property (gf && m |-> ##2 gfence_pulse)
        else $error("physical fence refused in machine mode");
    AST_FENCE_VIRT: assert property ((vf || gf) && vt
        |-> ##2 virtual_pulse)
        else $error("fence while virtualized not virtual fault");
    AST_FENCE_USER: assert property ((vf || gf) && u && !vt
        |-> ##2 illegal_pulse ##1 !illegal_pulse)
        else $error("fence from user not a single illegal pulse");
    CV_GUEST: cover property (guest_access_pulse);
    CV_VFENCE: cover property (vfence_pulse);
    CV_GFENCE: cover property (gfence_pulse);
    CV_VIRT: cover property (virtual_pulse);
endmodule
bind hgac_top hgac_asserts u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .illegal_pulse(illegal_pulse),
    .virtual_pulse(virtual_pulse), .guest_access_pulse(guest_access_pulse),
    .vfence_pulse(vfence_pulse), .gfence_pulse(gfence_pulse));
`default_nettype wire

// >>> bench/hgac_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "hgac_regs.vh"
module hgac_top_bench;
    // ----------------------------------------------------------------
    // signals and harness
    // ----------------------------------------------------------------
    localparam logic [31:0] LOAD_B = {`HGAC_F7_LD_B, `HGAC_LDSEL_SGN,
        5'h05, `HGAC_F3_PRIVM, 5'h06, `HGAC_OPC_SYSTEM};
    logic pclk, presetn, psel, penable, pwrite, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, ill, vir, gac, vfp, gfp;
    logic [4:0] pul;
    int bad_count = 0;
    int checks_done = 0;
    hgac_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .illegal_pulse(ill), .virtual_pulse(vir),
        .guest_access_pulse(gac), .vfence_pulse(vfp), .gfence_pulse(gfp));
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // request held until pready is seen high at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        check(rd, e);
    endtask
    function automatic logic [31:0] enc(input logic [6:0] f7,
        input logic [4:0] r2, input logic [4:0] r1, input logic [2:0] f3);
        return {f7, r2, r1, f3, 5'h00, `HGAC_OPC_SYSTEM};
    endfunction
    // outcome pulses land one edge after the instruction write
    task automatic run(input logic [11:0] c, input logic [31:0] ins);
        xfer(1'h1, `HGAC_OFF_CTRL, {20'h0, c});
        xfer(1'h1, `HGAC_OFF_INSTR, ins);
        #1;
        pul = {ill, vir, gac, vfp, gfp};
        @(posedge pclk);
        xfer(1'h0, `HGAC_OFF_RESULT, 32'h0);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rchk(`HGAC_OFF_CTRL, 32'h003);
        rchk(8'h40, 32'h0);
        check(er, 1'h1);
        xfer(1'h1, `HGAC_OFF_SCAUSE, 32'hFFFFFFFF);
        rchk(`HGAC_OFF_SCAUSE, 32'h8000001F);
        xfer(1'h1, `HGAC_OFF_VSCAUSE, 32'h12345678);
        rchk(`HGAC_OFF_VSCAUSE, 32'h00000018);
        xfer(1'h1, `HGAC_OFF_CTRL, 32'h005);
        xfer(1'h1, `HGAC_OFF_SCAUSE, 32'h80000003);
        xfer(1'h1, `HGAC_OFF_STVAL, 32'hDEADBEEF);
        xfer(1'h1, `HGAC_OFF_SATP, 32'h80000123);
        rchk(`HGAC_OFF_SCAUSE, 32'h80000003);
        xfer(1'h1, `HGAC_OFF_CTRL, 32'h001);
        rchk(`HGAC_OFF_SCAUSE, 32'h8000001F);
        rchk(`HGAC_OFF_VSCAUSE, 32'h80000003);
        rchk(`HGAC_OFF_VSTVAL, 32'hDEADBEEF);
        rchk(`HGAC_OFF_STVAL, 32'h0);
        rchk(`HGAC_OFF_VSATP, 32'h80000123);
        rchk(`HGAC_OFF_SATP, 32'h0);
    endtask
    task automatic t_modes();
        logic [11:0] c [7] = '{12'h003, 12'h001, 12'h005, 12'h000,
            12'h008, 12'h00C, 12'h007};
        logic [4:0] e [7] = '{5'h04, 5'h04, 5'h08, 5'h10, 5'h04, 5'h08,
            5'h04};
        for (int i = 0; i < 7; i++) begin
            run(c[i], LOAD_B);
            check(pul, e[i]);
            check(rd[2:0], {1'h1, e[i] == 5'h08, e[i] == 5'h10});
            run(c[i], enc(`HGAC_F7_ST_W, 5'h06, 5'h05, `HGAC_F3_PRIVM));
            check(pul, e[i]);
        end
    endtask
    task automatic t_fences();
        logic [11:0] c [7] = '{12'h003, 12'h023, 12'h061, 12'h001,
            12'h005, 12'h000, 12'h004};
        logic [9:0] e [7] = '{10'h041, 10'h041, 10'h050, 10'h041,
            10'h108, 10'h210, 10'h108};
        for (int i = 0; i < 7; i++) begin
            run(c[i], enc(`HGAC_F7_VFENCE, 5'h07, 5'h05, `HGAC_F3_PRIV));
            check(pul, e[i][9:5]);
            run(c[i], enc(`HGAC_F7_GFENCE, 5'h07, 5'h05, `HGAC_F3_PRIV));
            check(pul, e[i][4:0]);
        end
    endtask
    task automatic t_widths();
        logic [28:0] t [14] = '{{7'h34, 5'h01, 12'h003, 5'h10},
            {7'h36, 5'h00, 12'h003, 5'h10}, {7'h37, 5'h06, 12'h003, 5'h10},
            {7'h34, 5'h03, 12'h003, 5'h04}, {7'h32, 5'h03, 12'h003, 5'h04},
            {7'h30, 5'h01, 12'h003, 5'h04}, {7'h32, 5'h00, 12'h003, 5'h04},
            {7'h32, 5'h01, 12'h003, 5'h04}, {7'h34, 5'h00, 12'h003, 5'h04},
            {7'h31, 5'h06, 12'h003, 5'h04}, {7'h33, 5'h06, 12'h003, 5'h04},
            {7'h34, 5'h01, 12'h403, 5'h04}, {7'h36, 5'h00, 12'h403, 5'h04},
            {7'h37, 5'h06, 12'h403, 5'h04}};
        for (int i = 0; i < 14; i++) begin
            run(t[i][16:5], enc(t[i][28:22], t[i][21:17], 5'h05,
                `HGAC_F3_PRIVM));
            check(pul, t[i][4:0]);
        end
        run(12'h003, enc(7'h34, 5'h03, 5'h05, `HGAC_F3_PRIVM));
        check(rd[8:7], 2'h2);
        run(12'h003, enc(7'h32, 5'h03, 5'h05, `HGAC_F3_PRIVM));
        check({rd[21], rd[5], rd[3]}, 3'h7);
        check(rd[20], 1'h1);
    endtask
    task automatic t_fields();
        run(12'h013, LOAD_B);
        check(rd[11:9], 3'h3);
        run(12'h003, LOAD_B);
        check(rd[9], 1'h0);
        run(12'h283, LOAD_B);
        check(rd[12:10], 3'h5);
        run(12'h103, LOAD_B);
        check(rd[12], 1'h0);
        run(12'h803, LOAD_B);
        check(rd[15], 1'h0);
        run(12'h805, LOAD_B);
        check(rd[15], 1'h1);
        run(12'h008, LOAD_B);
        check(rd[14], 1'h1);
        run(12'h000, LOAD_B);
        check(rd[14], 1'h0);
    endtask
    task automatic t_operands();
        xfer(1'h1, `HGAC_OFF_RS1, 32'h00001234);
        xfer(1'h1, `HGAC_OFF_RS2, 32'hFFFFFFE5);
        run(12'h003, enc(`HGAC_F7_VFENCE, 5'h07, 5'h00, `HGAC_F3_PRIV));
        check(rd[19:18], 2'h2);
        rchk(`HGAC_OFF_FADDR, 32'h0);
        rchk(`HGAC_OFF_FID, 32'h25);
        run(12'h003, enc(`HGAC_F7_GFENCE, 5'h07, 5'h05, `HGAC_F3_PRIV));
        check(rd[19:18], 2'h3);
        rchk(`HGAC_OFF_FADDR, 32'h1234);
        rchk(`HGAC_OFF_FID, 32'h05);
    endtask
    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        #100us;
        bad_count++;
        complete_run();
    end
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        t_regs();
        t_modes();
        t_fences();
        t_widths();
        t_fields();
        t_operands();
        complete_run();
    end
endmodule
`default_nettype wire
